// File: devcap_defs.vh
/*
 * constants of the device capability and device control register bank:
 * byte offsets, field positions, reset values and bus answers.
 * assumes inclusion by devcap_ctrl.v only; definitions only.
 */
`ifndef DEVCAP_DEFS_VH
`define DEVCAP_DEFS_VH

// byte offsets on the register bus
`define OFS_DEVICE_CAPABILITIES 8'hC4
`define OFS_DEVICE_CONTROL 8'hC8
`define OFS_EVENT_STATUS 8'hD0
`define OFS_EVENT_MASK 8'hD4

// device_capabilities fields
`define CAP_MPS_LO 0
`define CAP_MPS_HI 2
`define CAP_RBER_BIT 15
`define CAP_SPL_VAL_LO 18
`define CAP_SPL_VAL_HI 25
`define CAP_SPL_SCL_LO 26
`define CAP_SPL_SCL_HI 27
`define CAP_MPS_SMALL 3'h1
`define CAP_MPS_LARGE 3'h2
`define CAP_RBER_RST 1'h1
`define CAP_SPL_VAL_RST 8'h00
`define CAP_SPL_SCL_RST 2'h0

// device_control fields (status flags sit in the upper half of the word)
`define CTL_ERR_EN_LO 0
`define CTL_ERR_EN_HI 3
`define CTL_MPS_LO 5
`define CTL_MPS_HI 7
`define CTL_AUX_BIT 10
`define CTL_ERR_FLAG_LO 16
`define CTL_ERR_FLAG_HI 19
`define CTL_ERR_EN_RST 4'h0
`define CTL_MPS_RST 3'h0
`define CTL_AUX_RST 1'h0

// event status / mask layout
`define EVT_WIDTH 5
`define EVT_SPL_BIT 4
`define EVT_RST 5'h00

// strap capture window after reset release, in clock cycles
`define STRAP_SETTLE 2'h3
// count at which the synchronised strap is copied into the capability
`define STRAP_LOAD_AT 2'h2

// bus answers
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// File: devcap_ctrl.v
/*
 * device capability and device control register bank of one switch port,
 * reached by an axi4-lite slave, with error flags and an event interrupt.
 * assumes: one 50 MHz clock aclk; aresetn is the conventional reset and
 * sticky_resetn the power-on reset (both synchronous, low active); the
 * strap and port-role pins are asynchronous; message, load and error
 * inputs come from logic on aclk as one-cycle pulses.
 */
// Our own choice: the AXI4-Lite register port.
// Operation
// - payload capability resets to 001b with strap low, 010b with strap high
// - strap, management bus or eeprom load may replace payload capability
// - phantom function support bits 4:3 read 00b
// - extended tag support bit 5 reads zero
// - endpoint latency fields 8:6 and 11:9 read 000b
// - role based error reporting bit 15 resets to one, loadable
// - upstream port captures slot power limit value into 25:18
// - upstream port captures slot power limit scale into 27:26
// - four error reporting enables in bits 3:0, reset to zero
// - relaxed ordering enable bit 4 reads zero
// - payload setting 7:5 resets 000b, writes above capability clamp
// - extended tag and phantom enables, bits 8 and 9, read zero
// - aux power enable bit 10 is sticky read write, resets zero
// - no snoop enable bit 11 reads zero
// - read request size 14:12 is hardwired 000b
// - detected errors set status flags regardless of enables
`timescale 1ns/100ps
`include "devcap_defs.vh"

module devcap_ctrl (
    // clock and resets
    input wire aclk,
    input wire aresetn,
    input wire sticky_resetn,
    // strap and role pins
    input wire large_payload_strap,
    input wire upstream_port_pin,
    // capability overrides from management bus or eeprom autoload
    input wire cap_load_valid,
    input wire [2:0] cap_load_payload,
    input wire cap_load_role_err,
    // received slot power limit message
    input wire spl_msg_valid,
    input wire [7:0] spl_msg_value,
    input wire [1:0] spl_msg_scale,
    // detected errors: correctable, non-fatal, fatal, unsupported request
    input wire [3:0] err_detect,
    // error messages towards the upstream link
    output reg [3:0] err_msg_q,
    // settings used by the datapath
    output reg [2:0] payload_size_q,
    output reg aux_power_en_q,
    // interrupt
    output reg irq_q,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // pin synchronisers
    reg strap_meta_q;
    reg strap_sync_q;
    reg role_meta_q;
    reg role_sync_q;
    reg [1:0] strap_cnt_q;

    // capability state
    reg [2:0] cap_mps_q;
    reg cap_rber_q;
    reg [7:0] spl_value_q;
    reg [1:0] spl_scale_q;

    // control and status state
    reg [3:0] err_en_q;
    reg [3:0] err_flag_q;
    reg [4:0] evt_status_q;
    reg [4:0] evt_mask_q;

    // write channel holding registers
    reg aw_held_q;
    reg [7:0] aw_addr_q;
    reg w_held_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    wire aw_hs;
    wire w_hs;
    wire ar_hs;
    wire wr_go;
    wire spl_take;
    wire [3:0] err_wr_clr;
    wire [4:0] evt_wr_clr;
    wire [4:0] evt_set;
    wire [31:0] cap_word;
    wire [31:0] ctl_word;

    // an unknown byte offset is answered with a decode error
    function mapped;
        input [7:0] addr;
        begin
            mapped = hits(addr, `OFS_DEVICE_CAPABILITIES) ||
                     hits(addr, `OFS_DEVICE_CONTROL) ||
                     hits(addr, `OFS_EVENT_STATUS) ||
                     hits(addr, `OFS_EVENT_MASK);
        end
    endfunction

    // limit a payload setting to what the port supports
    function [2:0] clamp_mps;
        input [2:0] want;
        input [2:0] cap;
        begin
            clamp_mps = (want > cap) ? cap : want;
        end
    endfunction

    function hits;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hits = (addr[7:2] == ofs[7:2]);
        end
    endfunction

    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign ar_hs = s_axi_arvalid & s_axi_arready;
    assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign spl_take = spl_msg_valid & role_sync_q;

    assign err_wr_clr = (wr_go && hits(aw_addr_q, `OFS_DEVICE_CONTROL) && w_strb_q[2]) ?
                        w_data_q[`CTL_ERR_FLAG_HI:`CTL_ERR_FLAG_LO] : 4'h0;
    assign evt_wr_clr = (wr_go && hits(aw_addr_q, `OFS_EVENT_STATUS) && w_strb_q[0]) ?
                        w_data_q[4:0] : 5'h00;
    assign evt_set = {spl_take, err_detect};

    // reserved and hardwired fields are built as zero constants
    assign cap_word = {4'h0, spl_scale_q, spl_value_q, 2'h0,
                       cap_rber_q, 3'h0, 3'h0, 3'h0, 1'h0, 2'h0, cap_mps_q};
    assign ctl_word = {12'h000, err_flag_q, 1'h0, 3'h0, 1'h0, aux_power_en_q,
                       1'h0, 1'h0, payload_size_q, 1'h0, err_en_q};

    // pins cross into aclk through two flip-flops each
    always @(posedge aclk) begin
        if (!aresetn) begin
            strap_meta_q <= 1'b0;
            strap_sync_q <= 1'b0;
            role_meta_q <= 1'b0;
            role_sync_q <= 1'b0;
        end else begin
            strap_meta_q <= large_payload_strap;
            strap_sync_q <= strap_meta_q;
            role_meta_q <= upstream_port_pin;
            role_sync_q <= role_meta_q;
        end
    end

    // the strap is only valid once the synchroniser has refilled after reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            strap_cnt_q <= 2'h0;
        end else if (strap_cnt_q != `STRAP_SETTLE) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
        end
    end

    // payload capability and role based error reporting capability
    always @(posedge aclk) begin
        if (!aresetn) begin
            cap_mps_q <= `CAP_MPS_SMALL;
            cap_rber_q <= `CAP_RBER_RST;
        end else if (cap_load_valid) begin
            cap_mps_q <= cap_load_payload;
            cap_rber_q <= cap_load_role_err;
        end else if (strap_cnt_q == `STRAP_LOAD_AT) begin
            cap_mps_q <= strap_sync_q ? `CAP_MPS_LARGE : `CAP_MPS_SMALL;
        end
    end

    // slot power limit, taken only when this is the upstream port
    always @(posedge aclk) begin
        if (!aresetn) begin
            spl_value_q <= `CAP_SPL_VAL_RST;
            spl_scale_q <= `CAP_SPL_SCL_RST;
        end else if (spl_take) begin
            spl_value_q <= spl_msg_value;
            spl_scale_q <= spl_msg_scale;
        end
    end

    // error reporting enables
    always @(posedge aclk) begin
        if (!aresetn) begin
            err_en_q <= `CTL_ERR_EN_RST;
        end else if (wr_go && hits(aw_addr_q, `OFS_DEVICE_CONTROL) && w_strb_q[0]) begin
            err_en_q <= w_data_q[`CTL_ERR_EN_HI:`CTL_ERR_EN_LO];
        end
    end

    // payload setting; a lowered capability pulls the setting down with it
    always @(posedge aclk) begin
        if (!aresetn) begin
            payload_size_q <= `CTL_MPS_RST;
        end else if (wr_go && hits(aw_addr_q, `OFS_DEVICE_CONTROL) && w_strb_q[0]) begin
            payload_size_q <= clamp_mps(w_data_q[`CTL_MPS_HI:`CTL_MPS_LO], cap_mps_q);
        end else begin
            payload_size_q <= clamp_mps(payload_size_q, cap_mps_q);
        end
    end

    // aux power enable survives the conventional reset
    always @(posedge aclk) begin
        if (!sticky_resetn) begin
            aux_power_en_q <= `CTL_AUX_RST;
        end else if (wr_go && hits(aw_addr_q, `OFS_DEVICE_CONTROL) && w_strb_q[1]) begin
            aux_power_en_q <= w_data_q[`CTL_AUX_BIT];
        end
    end

    // error flags log every detection; a new detection wins over a clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            err_flag_q <= 4'h0;
        end else begin
            err_flag_q <= (err_flag_q & ~err_wr_clr) | err_detect;
        end
    end

    // messages are gated by the enables, flags are not
    always @(posedge aclk) begin
        if (!aresetn) begin
            err_msg_q <= 4'h0;
        end else begin
            err_msg_q <= err_detect & err_en_q;
        end
    end

    // event status, mask and interrupt
    always @(posedge aclk) begin
        if (!aresetn) begin
            evt_status_q <= `EVT_RST;
            evt_mask_q <= `EVT_RST;
            irq_q <= 1'b0;
        end else begin
            evt_status_q <= (evt_status_q & ~evt_wr_clr) | evt_set;
            if (wr_go && hits(aw_addr_q, `OFS_EVENT_MASK) && w_strb_q[0]) begin
                evt_mask_q <= w_data_q[4:0];
            end
            irq_q <= |(evt_status_q & evt_mask_q);
        end
    end

    // write address and data are held until both are present
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_hs) begin
                s_axi_awready <= 1'b0;
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                s_axi_wready <= 1'b0;
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end
            // channels reopen only after the response is accepted
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // write response
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr_q) ? `RESP_OKAY : `RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel: one read in flight, data one cycle after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_DECERR;
            if (hits(s_axi_araddr, `OFS_DEVICE_CAPABILITIES)) begin
                s_axi_rdata <= cap_word;
            end else if (hits(s_axi_araddr, `OFS_DEVICE_CONTROL)) begin
                s_axi_rdata <= ctl_word;
            end else if (hits(s_axi_araddr, `OFS_EVENT_STATUS)) begin
                s_axi_rdata <= {27'h0000000, evt_status_q};
            end else if (hits(s_axi_araddr, `OFS_EVENT_MASK)) begin
                s_axi_rdata <= {27'h0000000, evt_mask_q};
            end else begin
                s_axi_rdata <= 32'h00000000;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // devcap_ctrl

// File: devcap_chk_chk.sv
/* checker bound to devcap_ctrl: bus answers, fixed bits and error message gating.
   assumes one clock aclk and synchronous low-active resets. */
`timescale 1ns/100ps
module devcap_chk (
    // clock and resets
    input wire aclk,
    input wire aresetn,
    input wire sticky_resetn,
    // events
    input wire [3:0] err_detect,
    input wire [3:0] err_msg_q,
    input wire aux_power_en_q,
    // write side
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // read side
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    reg [7:0] raddr_q;
    wire cap_rd = s_axi_rvalid && raddr_q == 8'hC4;
    wire ctl_rd = s_axi_rvalid && raddr_q == 8'hC8;
    wire mapped = cap_rd || ctl_rd || raddr_q == 8'hD0 || raddr_q == 8'hD4;
    // read address kept so the answer can be judged against it
    always @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            raddr_q <= s_axi_araddr;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered on next cycle");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data moved before taken");
    // both halves are held one edge before the answer is launched
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write not answered");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    a_read_resp: assert property (s_axi_rvalid |-> s_axi_rresp == (mapped ? 2'h0 : 2'h3))
        else $error("read response code wrong");
    a_cap_fixed: assert property (cap_rd |-> s_axi_rdata[31:28] == 4'h0
        && s_axi_rdata[17:16] == 2'h0 && s_axi_rdata[14:3] == 12'h000)
        else $error("capability fixed bits not zero");
    a_ctl_fixed: assert property (ctl_rd |-> s_axi_rdata[31:20] == 12'h000
        && s_axi_rdata[15:11] == 5'h00 && s_axi_rdata[9:8] == 2'h0 && !s_axi_rdata[4])
        else $error("control fixed bits not zero");
    a_msg_gate: assert property (err_msg_q != 4'h0 |-> (err_msg_q & ~$past(err_detect)) == 4'h0)
        else $error("error message without detected error");
    a_aux_cause: assert property ($changed(aux_power_en_q) |-> $past(s_axi_wvalid)
        || $past(s_axi_wvalid, 2) || !$past(sticky_resetn)) else $error("aux enable moved alone");
    c_decerr: cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
    c_msg: cover property (err_msg_q != 4'h0);
    c_aux: cover property ($rose(aux_power_en_q));
endmodule // devcap_chk

bind devcap_ctrl devcap_chk i_chk (.*);

// File: devcap_host.sv
/* host side: axi4-lite master issuing register reads and writes.
   assumes one clock aclk; callers start after reset is released. */
`timescale 1ns/100ps
module devcap_host (
    // clock
    input wire aclk,
    // write side
    output logic [7:0] s_axi_awaddr = 8'h00,
    output logic s_axi_awvalid = 1'b0,
    input wire s_axi_awready,
    output logic [31:0] s_axi_wdata = 32'h00000000,
    output logic [3:0] s_axi_wstrb = 4'h0,
    output logic s_axi_wvalid = 1'b0,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    output logic s_axi_bready = 1'b0,
    // read side
    output logic [7:0] s_axi_araddr = 8'h00,
    output logic s_axi_arvalid = 1'b0,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    output logic s_axi_rready = 1'b0
);
    // released address and data lines carry inverted values so a late sample cannot match by luck
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            begin
                do @(posedge aclk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        join
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule // devcap_host

// File: pcie_switch_device_cap_ctrl_tb.sv
/* self-checking bench for the device capability and control bank.
   assumes devcap_ctrl, devcap_host and the bound checker are compiled. */
`timescale 1ns/100ps
module pcie_switch_device_cap_ctrl_tb;
    typedef struct packed {
        logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e; logic [1:0] r;
    } row_t;
    logic aclk = 1'b0, aresetn = 1'b0, sticky_resetn = 1'b0, spl_msg_valid = 1'b0;
    logic large_payload_strap = 1'b1, upstream_port_pin = 1'b1;
    logic cap_load_valid = 1'b0, cap_load_role_err = 1'b0;
    logic [2:0] cap_load_payload = 3'h0, s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [7:0] spl_msg_value = 8'h00, s_axi_awaddr, s_axi_araddr;
    logic [1:0] spl_msg_scale = 2'h0, s_axi_bresp, s_axi_rresp, br, rr;
    logic [3:0] err_detect = 4'h0, err_msg_q, s_axi_wstrb;
    logic [2:0] payload_size_q;
    logic aux_power_en_q, irq_q, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    int bad_count = 0, n_compared = 0;
    row_t rows [6] = '{
        '{8'hC8, 32'hFFFF7FFF, 4'hF, 32'h0000044F, 2'h0},
        '{8'hC8, 32'h00000020, 4'h1, 32'h00000420, 2'h0},
        '{8'hC4, 32'hFFFFFFFF, 4'hF, 32'h00008002, 2'h0},
        '{8'hD4, 32'h0000001F, 4'h1, 32'h0000001F, 2'h0},
        '{8'h40, 32'h12345678, 4'hF, 32'h00000000, 2'h3},
        '{8'hC8, 32'h00000000, 4'hF, 32'h00000000, 2'h0}};

    always #10 aclk = ~aclk;
    devcap_ctrl i_dut (.*);
    devcap_host i_host (.*);

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        i_host.rd(a, rd, rr);
        chk("rdata", e, rd);
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        i_host.wr(a, d, s, br);
    endtask
    task automatic rst(input logic all);
        aresetn <= 1'b0;
        sticky_resetn <= !all;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        sticky_resetn <= 1'b1;
        repeat (4) @(posedge aclk);
    endtask
    task automatic load(input logic [2:0] p, input logic re);
        cap_load_payload <= p;
        cap_load_role_err <= re;
        cap_load_valid <= 1'b1;
        @(posedge aclk);
        cap_load_valid <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic spl(input logic [7:0] v, input logic [1:0] s);
        spl_msg_value <= v;
        spl_msg_scale <= s;
        spl_msg_valid <= 1'b1;
        @(posedge aclk);
        spl_msg_valid <= 1'b0;
    endtask
    task automatic err(input logic [3:0] e);
        err_detect <= 4'hF;
        @(posedge aclk);
        err_detect <= 4'h0;
        #1 chk("err_msg_q", {28'h0, e}, {28'h0, err_msg_q});
        // hand back on an edge so the next stimulus is launched there
        @(posedge aclk);
    endtask
    task automatic irqc(input logic e);
        repeat (3) @(posedge aclk);
        #1 chk("irq_q", {31'h0, e}, {31'h0, irq_q});
        @(posedge aclk);
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // the tests need under 200 cycles; thirty times that means a hang
    initial begin
        #120000;
        bad_count++;
        results();
    end

    initial begin
        rst(1'b1);
        foreach (rows[i]) begin
            i_host.wr(rows[i].a, rows[i].d, rows[i].s, br);
            chk("bresp", {30'h0, rows[i].r}, {30'h0, br});
            rdc(rows[i].a, rows[i].e);
            chk("rresp", {30'h0, rows[i].r}, {30'h0, rr});
        end
        $display("test table done");
        w(8'hC8, 32'h00000400, 4'h2);
        rst(1'b0);
        chk("aux", 32'h1, {31'h0, aux_power_en_q});
        rdc(8'hC8, 32'h00000400);
        rst(1'b1);
        chk("aux", 32'h0, {31'h0, aux_power_en_q});
        $display("test sticky done");
        large_payload_strap <= 1'b0;
        rst(1'b0);
        rdc(8'hC4, 32'h00008001);
        w(8'hC8, 32'h000000E0, 4'h1);
        rdc(8'hC8, 32'h00000020);
        load(3'h2, 1'b0);
        rdc(8'hC4, 32'h00000002);
        w(8'hC8, 32'h000000E0, 4'h1);
        load(3'h1, 1'b1);
        #1 chk("payload", 32'h1, {29'h0, payload_size_q});
        rdc(8'hC4, 32'h00008001);
        $display("test capability done");
        err(4'h0);
        rdc(8'hC8, 32'h000F0020);
        w(8'hC8, 32'h00000025, 4'h1);
        err(4'h5);
        w(8'hC8, 32'h000F0000, 4'h4);
        rdc(8'hC8, 32'h00000025);
        rdc(8'hD0, 32'h0000000F);
        $display("test errors done");
        w(8'hD0, 32'h0000001F, 4'h1);
        w(8'hD4, 32'h00000010, 4'h1);
        spl(8'hA5, 2'h2);
        irqc(1'b1);
        rdc(8'hC4, 32'h0A948001);
        w(8'hD4, 32'h00000000, 4'h1);
        irqc(1'b0);
        w(8'hD4, 32'h00000010, 4'h1);
        irqc(1'b1);
        w(8'hD0, 32'h00000010, 4'h1);
        irqc(1'b0);
        upstream_port_pin <= 1'b0;
        repeat (4) @(posedge aclk);
        spl(8'h3C, 2'h1);
        rdc(8'hC4, 32'h0A948001);
        $display("test slot power done");
        results();
    end
endmodule // pcie_switch_device_cap_ctrl_tb
